// ---- design/pmic_interrupt_status_irq.sv ----
// Interrupt status registers, source masks, pin trigger modes and the
// interrupt pin driver of the power-management device, on an APB slave.
// Assumes pclk at 10 MHz, event inputs asynchronous to it, and an
// external resolver that turns the pin output and enable into a wire.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module pmic_interrupt_status_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmic_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] conv_high_current,
  input wire logic [3:0] conv_undervoltage,
  input wire logic osc_start_fail,
  input wire logic osc_tamper,
  input wire logic [pmic_irq_pkg::GPIO_N-1:0] gpio_in,
  output logic irq_pin_n_o,
  output logic irq_pin_oe
);

  // Byte addresses derived from register indices
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_STAT_CONV =
    {pmic_irq_pkg::STAT_CONV_IDX, 2'b00};
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_STAT_GPIO =
    {pmic_irq_pkg::STAT_GPIO_IDX, 2'b00};
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_PIN_CFG =
    {pmic_irq_pkg::PIN_CFG_IDX, 2'b00};
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_MASK_CONV =
    {pmic_irq_pkg::MASK_CONV_IDX, 2'b00};
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_MASK_GPIO =
    {pmic_irq_pkg::MASK_GPIO_IDX, 2'b00};
  localparam logic [pmic_irq_pkg::ADDR_W-1:0] A_TRIG_MODE =
    {pmic_irq_pkg::TRIG_MODE_IDX, 2'b00};

  // Edge pulses of the converter and oscillator group
  logic [7:0] conv_rise;
  logic [7:0] conv_fall;
  // Edge pulses of the pins
  logic [pmic_irq_pkg::GPIO_N-1:0] gpio_rise;
  logic [pmic_irq_pkg::GPIO_N-1:0] gpio_fall;

  // Status flags, masks and configuration
  logic [15:0] stat_conv_q;
  logic [15:0] stat_conv_d;
  logic [15:0] stat_gpio_q;
  logic [15:0] stat_gpio_d;
  logic [15:0] mask_conv_q;
  logic [15:0] mask_gpio_q;
  logic [23:0] trig_mode_q;
  logic int_pin_open_drain_sel;
  logic int_pin_output_mask;

  // Set and clear vectors
  logic [15:0] set_conv;
  logic [15:0] set_gpio;
  logic [15:0] clr_conv;
  logic [15:0] clr_gpio;

  // APB decode
  logic setup_ph;
  logic wr_en;
  logic [31:0] wmask;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic pend;
  logic irq_want;

  // Convenience names of the converter group status flags
  logic conv2_high_current_flag;
  logic conv1_high_current_flag;
  logic osc_start_fail_flag;
  logic osc_tamper_flag;

  event_edge_detect #(
    .WIDTH(8)
  ) u_conv_edges (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({conv_high_current, osc_start_fail, osc_tamper, conv_undervoltage}),
    .rise(conv_rise),
    .fall(conv_fall)
  );

  event_edge_detect #(
    .WIDTH(pmic_irq_pkg::GPIO_N)
  ) u_gpio_edges (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(gpio_in),
    .rise(gpio_rise),
    .fall(gpio_fall)
  );

  // Set vector for the converter status register
  always_comb begin
    set_conv = 16'h0000;
    set_conv[pmic_irq_pkg::CONV2_HC_BIT] = conv_rise[7];
    set_conv[pmic_irq_pkg::CONV1_HC_BIT] = conv_rise[6];
    set_conv[pmic_irq_pkg::OSC_FAIL_BIT] = conv_rise[5];
    set_conv[pmic_irq_pkg::OSC_TAMPER_BIT] = conv_rise[4] | conv_fall[4];
    set_conv[pmic_irq_pkg::CONV4_UV_BIT:pmic_irq_pkg::CONV1_UV_BIT] = conv_rise[3:0];
  end

  // Named views of the converter group, for debug visibility
  assign conv2_high_current_flag = stat_conv_q[pmic_irq_pkg::CONV2_HC_BIT];
  assign conv1_high_current_flag = stat_conv_q[pmic_irq_pkg::CONV1_HC_BIT];
  assign osc_start_fail_flag = stat_conv_q[pmic_irq_pkg::OSC_FAIL_BIT];
  assign osc_tamper_flag = stat_conv_q[pmic_irq_pkg::OSC_TAMPER_BIT];

  genvar g;
  generate
    for (g = 0; g < pmic_irq_pkg::GPIO_N; g++) begin : g_pin
      pmic_irq_pkg::pin_trigger_t mode;
      assign mode = pmic_irq_pkg::pin_trigger_t'(trig_mode_q[2*g+1:2*g]);
      assign set_gpio[g] = (mode == pmic_irq_pkg::TRIG_RISE) ? gpio_rise[g] :
                           (mode == pmic_irq_pkg::TRIG_FALL) ? gpio_fall[g] :
                           (mode == pmic_irq_pkg::TRIG_BOTH) ? (gpio_rise[g] | gpio_fall[g]) :
                           1'b0;
    end
  endgenerate
  // Unused upper bits of the pin status never set
  assign set_gpio[15:pmic_irq_pkg::GPIO_N] = '0;

  // Setup phase of a transfer
  assign setup_ph = psel & ~penable;
  // Write lands at the access edge the slave completes
  assign wr_en = psel & penable & pwrite & pready & ~pslverr;
  // Byte lanes from the strobes
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign clr_conv = (wr_en && paddr == A_STAT_CONV) ? (pwdata[15:0] & wmask[15:0]) : 16'h0000;
  assign clr_gpio = (wr_en && paddr == A_STAT_GPIO) ? (pwdata[15:0] & wmask[15:0]) : 16'h0000;

  // a same-cycle edge outranks the clear
  assign stat_conv_d = ((stat_conv_q & ~clr_conv) | set_conv) & pmic_irq_pkg::STAT_CONV_USED;
  assign stat_gpio_d = ((stat_gpio_q & ~clr_gpio) | set_gpio) & pmic_irq_pkg::STAT_GPIO_USED;

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_conv_q <= pmic_irq_pkg::STAT_RST;
      stat_gpio_q <= pmic_irq_pkg::STAT_RST;
    end else begin
      stat_conv_q <= stat_conv_d;
      stat_gpio_q <= stat_gpio_d;
    end
  end

  // Source masks and trigger modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_conv_q <= pmic_irq_pkg::MASK_CONV_RST;
      mask_gpio_q <= pmic_irq_pkg::MASK_GPIO_RST;
      trig_mode_q <= pmic_irq_pkg::TRIG_MODE_RST;
    end else if (wr_en) begin
      // Byte-lane merge of each writable register
      if (paddr == A_MASK_CONV) begin
        mask_conv_q <= ((mask_conv_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]))
                       & pmic_irq_pkg::STAT_CONV_USED;
      end
      if (paddr == A_MASK_GPIO) begin
        mask_gpio_q <= ((mask_gpio_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]))
                       & pmic_irq_pkg::STAT_GPIO_USED;
      end
      if (paddr == A_TRIG_MODE) begin
        trig_mode_q <= (trig_mode_q & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
    end
  end

  // Pin configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pin_open_drain_sel <= pmic_irq_pkg::OPEN_DRAIN_RST;
      int_pin_output_mask <= pmic_irq_pkg::OUT_MASK_RST;
    end else if (wr_en && paddr == A_PIN_CFG && pstrb[0]) begin
      int_pin_open_drain_sel <= pwdata[pmic_irq_pkg::OPEN_DRAIN_BIT];
      int_pin_output_mask <= pwdata[pmic_irq_pkg::OUT_MASK_BIT];
    end
  end

  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      A_STAT_CONV: begin
        rd_mux[15:0] = stat_conv_q;
      end
      A_STAT_GPIO: begin
        rd_mux[15:0] = stat_gpio_q;
      end
      A_PIN_CFG: begin
        rd_mux[pmic_irq_pkg::OPEN_DRAIN_BIT] = int_pin_open_drain_sel;
        rd_mux[pmic_irq_pkg::OUT_MASK_BIT] = int_pin_output_mask;
      end
      A_MASK_CONV: begin
        rd_mux[15:0] = mask_conv_q;
      end
      A_MASK_GPIO: begin
        rd_mux[15:0] = mask_gpio_q;
      end
      A_TRIG_MODE: begin
        rd_mux[23:0] = trig_mode_q;
      end
      default: begin
        // Unmapped address answers with an error
        addr_hit = 1'b0;
      end
    endcase
  end

  // APB answer: ready in the first access cycle, data caught at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_hit;
      if (setup_ph && !pwrite && addr_hit) begin
        prdata <= rd_mux;
      end else if (setup_ph) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // a set mask bit blocks its source
  assign pend = |(stat_conv_q & ~mask_conv_q) | |(stat_gpio_q & ~mask_gpio_q);
  assign irq_want = pend & ~int_pin_output_mask;

  // Active-low pin driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_n_o <= 1'b0;
      irq_pin_oe <= 1'b0;
    end else if (int_pin_open_drain_sel) begin
      // open drain pulls low only when asserted
      irq_pin_n_o <= 1'b0;
      irq_pin_oe <= irq_want;
    end else begin
      irq_pin_n_o <= ~irq_want;
      irq_pin_oe <= 1'b1;
    end
  end

  // Pin reads as asserted: driven low, whatever the driver kind
  logic pin_active;
  assign pin_active = irq_pin_oe & ~irq_pin_n_o;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  flag_hold_a: assert property (
    ##1 ((stat_conv_q & $past(stat_conv_q & ~clr_conv)) == $past(stat_conv_q & ~clr_conv)))
    else $error("converter flag lost without a written one");

  flag_clear_a: assert property (
    (clr_gpio != 16'h0000 && set_gpio == 16'h0000) |=> ((stat_gpio_q & $past(clr_gpio)) == 16'h0000))
    else $error("pin flag not cleared by written one");

  hc_rise_a: assert property (
    conv_rise[7] |=> stat_conv_q[pmic_irq_pkg::CONV2_HC_BIT])
    else $error("high current edge did not set flag");

  uv_rise_a: assert property (
    conv_rise[0] |=> stat_conv_q[pmic_irq_pkg::CONV1_UV_BIT])
    else $error("undervoltage edge did not set flag");

  osc_fail_a: assert property (
    $rose(u_conv_edges.sync_q[5]) |=> stat_conv_q[pmic_irq_pkg::OSC_FAIL_BIT])
    else $error("start failure edge did not set flag");

  tamper_fall_a: assert property (
    $fell(u_conv_edges.sync_q[4]) |=> stat_conv_q[pmic_irq_pkg::OSC_TAMPER_BIT])
    else $error("tamper falling edge did not set flag");

  pin_fall_mode_a: assert property (
    (gpio_fall[1] && trig_mode_q[3:2] == pmic_irq_pkg::TRIG_FALL) |=> stat_gpio_q[1])
    else $error("falling mode pin edge did not set flag");

  pin_rise_ignored_a: assert property (
    (gpio_rise[1] && trig_mode_q[3:2] == pmic_irq_pkg::TRIG_FALL && !stat_gpio_q[1])
    |=> !stat_gpio_q[1])
    else $error("falling mode pin set on rising edge");

  od_drive_a: assert property (
    int_pin_open_drain_sel |=> !irq_pin_n_o)
    else $error("open drain pin drove high");

  out_mask_a: assert property (
    int_pin_output_mask [*2] |-> !pin_active)
    else $error("masked pin still asserted");

  irq_level_a: assert property (
    $stable(int_pin_open_drain_sel) |-> (pin_active == $past(irq_want)))
    else $error("pin level does not follow pending sources");

  src_mask_a: assert property (
    (mask_conv_q == pmic_irq_pkg::MASK_CONV_RST && mask_gpio_q == pmic_irq_pkg::MASK_GPIO_RST)
    |=> !pin_active)
    else $error("fully masked sources raised the pin");

  set_wins_a: assert property (
    (set_conv[pmic_irq_pkg::OSC_FAIL_BIT] && clr_conv[pmic_irq_pkg::OSC_FAIL_BIT])
    |=> stat_conv_q[pmic_irq_pkg::OSC_FAIL_BIT])
    else $error("clear beat a same cycle edge");

  irq_raise_c: cover property (!pin_active ##1 pin_active);
  clear_write_c: cover property (clr_conv != 16'h0000 ##1 stat_conv_q == 16'h0000);
  set_clear_c: cover property (|(set_gpio & clr_gpio));
  err_resp_c: cover property (pslverr);

endmodule

// ---- design/pmic_irq_pkg.sv ----
// Constants shared by the interrupt status and pin configuration block.
// Assumes a 32-bit APB slave with one register per aligned word.
package pmic_irq_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] STAT_CONV_IDX = 16'h4014;
  localparam logic [15:0] STAT_GPIO_IDX = 16'h4015;
  localparam logic [15:0] PIN_CFG_IDX = 16'h4017;
  // Added registers: source masks and pin trigger modes
  localparam logic [15:0] MASK_CONV_IDX = 16'h401C;
  localparam logic [15:0] MASK_GPIO_IDX = 16'h401D;
  localparam logic [15:0] TRIG_MODE_IDX = 16'h401E;

  // APB address width covering the byte addresses above
  localparam int ADDR_W = 18;

  // Converter and oscillator status field positions
  localparam int CONV2_HC_BIT = 9;
  localparam int CONV1_HC_BIT = 8;
  localparam int OSC_FAIL_BIT = 7;
  localparam int OSC_TAMPER_BIT = 6;
  localparam int CONV4_UV_BIT = 3;
  localparam int CONV1_UV_BIT = 0;

  // Used bits of the converter status register
  localparam logic [15:0] STAT_CONV_USED = 16'h03CF;
  // Used bits of the pin status register
  localparam logic [15:0] STAT_GPIO_USED = 16'h0FFF;

  // Pin configuration field positions and reset value
  localparam int OPEN_DRAIN_BIT = 1;
  localparam int OUT_MASK_BIT = 0;
  localparam logic OPEN_DRAIN_RST = 1'b1;
  localparam logic OUT_MASK_RST = 1'b0;

  // Flags reset clear, masks reset to all used bits set
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] MASK_CONV_RST = STAT_CONV_USED;
  localparam logic [15:0] MASK_GPIO_RST = STAT_GPIO_USED;

  // Number of general-purpose pins, two trigger bits each
  localparam int GPIO_N = 12;
  localparam logic [23:0] TRIG_MODE_RST = 24'h000000;

  // Per-pin edge sensitivity
  typedef enum logic [1:0] {
    TRIG_RISE = 2'b00,
    TRIG_FALL = 2'b01,
    TRIG_BOTH = 2'b11,
    TRIG_OFF = 2'b10
  } pin_trigger_t;

endpackage

// ---- design/event_edge_detect.sv ----
// Synchroniser and edge detector for a vector of asynchronous event levels.
// Assumes inputs come from outside the pclk domain.
`timescale 1ns/1ps
module event_edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  // Three-stage chain; stage one is read only by stage two
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Shift each input through the chain
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
          prev_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      assign rise[i] = sync_q[i] & ~prev_q[i];
      assign fall[i] = ~sync_q[i] & prev_q[i];
    end
  endgenerate

endmodule

// ---- tb/irq_host_model.sv ----
// Host end of the interrupt line: resolves the pin and flags a request.
// Assumes the device's pin output value and drive enable as inputs.
`timescale 1ns/1ps
module irq_host_model (
  input wire logic pin_n_o,
  input wire logic pin_oe,
  output logic irq_line,
  output logic irq_seen
);
  assign irq_line = pin_oe ? pin_n_o : 1'b1;
  assign irq_seen = ~irq_line;
endmodule

// ---- tb/pmic_interrupt_status_irq_tb_top.sv ----
// Self-checking bench for the interrupt status and pin block.
// Assumes a 10 MHz APB clock and the host model on the interrupt pin.
`timescale 1ns/1ps
module pmic_interrupt_status_irq_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [pmic_irq_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] conv_high_current;
  logic [3:0] conv_undervoltage;
  logic osc_start_fail;
  logic osc_tamper;
  logic [pmic_irq_pkg::GPIO_N-1:0] gpio_in;
  logic irq_pin_n_o;
  logic irq_pin_oe;
  logic irq_line;
  logic irq_seen;
  // Result counters and the hang guard
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // Last read data and error response
  logic [31:0] rd;
  logic err;

  pmic_interrupt_status_irq dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_high_current(conv_high_current), .conv_undervoltage(conv_undervoltage),
    .osc_start_fail(osc_start_fail), .osc_tamper(osc_tamper), .gpio_in(gpio_in),
    .irq_pin_n_o(irq_pin_n_o), .irq_pin_oe(irq_pin_oe)
  );

  irq_host_model host_u (
    .pin_n_o(irq_pin_n_o), .pin_oe(irq_pin_oe), .irq_line(irq_line), .irq_seen(irq_seen)
  );

  // Free-running 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // One APB transfer, waiting for pready, then one idle edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Word comparison
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-bit comparison
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read a register and compare it
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk_word(rd, exp);
  endtask

  // Let synchroniser, flag and pin settle
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  // Reset values, unmapped access, idle pin
  task automatic test_reset();
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0000);
    rdc(pmic_irq_pkg::STAT_GPIO_IDX, 32'h0000_0000);
    rdc(pmic_irq_pkg::PIN_CFG_IDX, 32'h0000_0002);
    rdc(pmic_irq_pkg::MASK_CONV_IDX, 32'h0000_03CF);
    rdc(pmic_irq_pkg::MASK_GPIO_IDX, 32'h0000_0FFF);
    rdc(pmic_irq_pkg::TRIG_MODE_IDX, 32'h0000_0000);
    apb(1'b0, 16'h4016, 32'h0000_0000);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0000_0000);
    chk_bit(irq_seen, 1'b0);
    $display("test_reset done");
  endtask

  // Converter and oscillator edges, write-one clearing
  task automatic test_conv();
    conv_high_current <= 2'h3;
    conv_undervoltage <= 4'hF;
    osc_start_fail <= 1'b1;
    osc_tamper <= 1'b1;
    settle();
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_03CF);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0000);
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_03CF);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_00C1);
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_030E);
    // Falling edges: only the tamper flag reacts
    conv_high_current <= 2'h0;
    conv_undervoltage <= 4'h0;
    osc_start_fail <= 1'b0;
    osc_tamper <= 1'b0;
    settle();
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_034E);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_FFFF);
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0000);
    $display("test_conv done");
  endtask

  // Pin 1 rising, 2 falling, 3 both, 4 off, 12 rising
  task automatic test_gpio();
    apb(1'b1, pmic_irq_pkg::TRIG_MODE_IDX, 32'h0000_00B4);
    rdc(pmic_irq_pkg::TRIG_MODE_IDX, 32'h0000_00B4);
    gpio_in <= 12'h80F;
    settle();
    rdc(pmic_irq_pkg::STAT_GPIO_IDX, 32'h0000_0805);
    apb(1'b1, pmic_irq_pkg::STAT_GPIO_IDX, 32'h0000_0FFF);
    gpio_in <= 12'h000;
    settle();
    rdc(pmic_irq_pkg::STAT_GPIO_IDX, 32'h0000_0006);
    apb(1'b1, pmic_irq_pkg::STAT_GPIO_IDX, 32'h0000_0FFF);
    $display("test_gpio done");
  endtask

  // Source masks, output mask and driver kind on the pin
  task automatic test_pin();
    apb(1'b1, pmic_irq_pkg::MASK_CONV_IDX, 32'h0000_03CE);
    conv_high_current <= 2'h1;
    settle();
    chk_bit(irq_seen, 1'b0);
    conv_undervoltage <= 4'h1;
    settle();
    chk_bit(irq_seen, 1'b1);
    chk_bit(irq_pin_oe, 1'b1);
    apb(1'b1, pmic_irq_pkg::PIN_CFG_IDX, 32'h0000_0003);
    settle();
    chk_bit(irq_seen, 1'b0);
    chk_bit(irq_pin_oe, 1'b0);
    apb(1'b1, pmic_irq_pkg::PIN_CFG_IDX, 32'h0000_0000);
    settle();
    chk_bit(irq_seen, 1'b1);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0001);
    settle();
    chk_bit(irq_seen, 1'b0);
    chk_bit(irq_pin_oe, 1'b1);
    apb(1'b1, pmic_irq_pkg::MASK_CONV_IDX, 32'h0000_02CF);
    settle();
    chk_bit(irq_seen, 1'b1);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_03FF);
    settle();
    chk_bit(irq_seen, 1'b0);
    $display("test_pin done");
  endtask

  // A new edge landing on the clearing write keeps the flag
  task automatic test_set_wins();
    osc_start_fail <= 1'b1;
    settle();
    osc_start_fail <= 1'b0;
    settle();
    osc_start_fail <= 1'b1;
    // Setup one edge later puts the clearing edge on the flag-setting edge
    repeat (1) @(posedge pclk);
    apb(1'b1, pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0080);
    rdc(pmic_irq_pkg::STAT_CONV_IDX, 32'h0000_0080);
    $display("test_set_wins done");
  endtask

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    conv_high_current = 2'h0;
    conv_undervoltage = 4'h0;
    osc_start_fail = 1'b0;
    osc_tamper = 1'b0;
    gpio_in = 12'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_conv();
    test_gpio();
    test_pin();
    test_set_wins();
    wrap_up();
  end
endmodule
